// ===== rtl/dds_slope_pkg.sv
// Package for the DDS slope and phase-update block.
// Assumes a single 125 MHz update clock shared by all cores.
`default_nettype none
package dds_slope_pkg;
   localparam int FREQ_W = 32;
   localparam int LEVEL_W = 16;
   localparam int PHASE_W = 12;
   localparam int DIV_W = 13;
   localparam int DIV_MIN = 1;
   localparam int DIV_MAX = 4096;
   localparam int PHASE_STEPS = 4096;
   localparam real CLOCK_MHZ = 125.0;
   localparam real UPDATE_NS = 8.0;
   localparam int UPDATE_CYCLES = 1;
   localparam logic signed [FREQ_W-1:0] FREQ_MIN_CODE = 32'sh00000000;
   localparam logic signed [FREQ_W-1:0] FREQ_MAX_CODE = 32'sh7FFFFFFF;
   localparam logic signed [LEVEL_W-1:0] LEVEL_MIN_CODE = 16'sh8001;
   localparam logic signed [LEVEL_W-1:0] LEVEL_MAX_CODE = 16'sh7FFF;
   localparam logic signed [FREQ_W-1:0] FREQ_RATE_MIN = 32'sh80000001;
   localparam logic signed [FREQ_W-1:0] FREQ_RATE_MAX = 32'sh7FFFFFFF;
   localparam logic signed [FREQ_W-1:0] FREQ_RATE_STEP = 32'sh00000001;
   localparam logic signed [LEVEL_W-1:0] LEVEL_RATE_MIN = 16'sh8001;
   localparam logic signed [LEVEL_W-1:0] LEVEL_RATE_MAX = 16'sh7FFF;
   localparam logic signed [LEVEL_W-1:0] LEVEL_RATE_STEP = 16'sh0001;
   localparam logic [DIV_W-1:0] DIV_RESET = 13'h0001;

   typedef enum logic {
      phase_reload_policy = 1'b0,
      phase_additive_policy = 1'b1
   } phase_policy_type;

   typedef enum logic [1:0] {
      cmd_idle = 2'h0,
      apply_immediately_cmd = 2'h1,
      apply_on_event_cmd = 2'h2
   } command_type;

   typedef struct packed {
      logic signed [FREQ_W-1:0] toneFrequency;
      logic signed [LEVEL_W-1:0] outputLevel;
      logic [PHASE_W-1:0] phaseOffset;
      logic signed [FREQ_W-1:0] freqRampRate;
      logic signed [LEVEL_W-1:0] levelRampRate;
   } core_setting_type;
endpackage : dds_slope_pkg
`default_nettype wire

// ===== rtl/ramp_pacer.sv
// Divider that paces ramp increments: one tick every divider cycles.
// Assumes the divider value is already limited to its legal range.
`default_nettype none
module ramp_pacer #(
   parameter int DIV_W = dds_slope_pkg::DIV_W
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [DIV_W-1:0] divider,
   output logic tick
);
   logic [DIV_W-1:0] count;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         count <= '0;
      end else if (count + DIV_W'(1) >= divider) begin
         count <= '0;
      end else begin
         count <= count + DIV_W'(1);
      end
   end

   assign tick = (count + DIV_W'(1) >= divider);
endmodule : ramp_pacer
`default_nettype wire

// ===== rtl/ramp_accumulator.sv
// Saturating signed accumulator for one ramped quantity of one core.
// Assumes a load pulse and a step tick from the core controller.
`default_nettype none
module ramp_accumulator #(
   parameter int W = 16,
   parameter logic signed [W-1:0] LOW = '0,
   parameter logic signed [W-1:0] HIGH = '1
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic load,
   input wire logic signed [W-1:0] loadValue,
   input wire logic step,
   input wire logic signed [W-1:0] rate,
   output logic signed [W-1:0] value
);
   logic signed [W:0] sum;

   // One extra bit lets the sum be checked before clamping
   assign sum = {value[W-1], value} + {rate[W-1], rate};

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         value <= '0;
      end else if (load) begin
         value <= loadValue;
      end else if (step && rate != '0) begin
         // Concatenations are unsigned; compare signed or negatives clamp high
         if (sum > $signed({HIGH[W-1], HIGH})) begin
            value <= HIGH;
         end else if (sum < $signed({LOW[W-1], LOW})) begin
            value <= LOW;
         end else begin
            value <= sum[W-1:0];
         end
      end
   end
endmodule : ramp_accumulator
`default_nettype wire

// ===== rtl/dds_slope_and_phase_control.sv
// Slope and phase-update control for a bank of DDS cores.
// Assumes shadow settings are written by the host, then applied by a
// command or, once apply_on_event_cmd has armed it, by the trigger/timer event pulse from outside.
// Summary of operation
// - nonzero slope adds signed increment each step
// - increments applied at DDS update rate
// - one small increment per step, no jumps
// - frequency rate signed; positive raises frequency
// - frequency rate rounded; readback returns used
// - level rate signed; positive raises level
// - level rate rounded; readback returns applied value
// - level ramp only on dedicated cores
// - frequency rate floor, ceiling, granule readable
// - level rate floor, ceiling, granule readable
// - frequency divider 1..4096 spaces ramp steps
// - level divider 1..4096 spaces ramp steps
// - one global phase policy for all cores
// - code 0 reloads phase at event
// - code 1 adds phase to counter
// - reload policy resets phase counter on event
// - additive policy adds phase at event
// - immediate command applies settings at once
// - level is signed scale, full negative inverts
// - phase has 4096 steps per turn
`default_nettype none
module dds_slope_and_phase_control #(
   parameter int CORES = 4,
   parameter logic [CORES-1:0] LEVEL_RAMP_CORES = 4'h1,
   parameter int FREQ_W = dds_slope_pkg::FREQ_W,
   parameter int LEVEL_W = dds_slope_pkg::LEVEL_W,
   parameter int PHASE_W = dds_slope_pkg::PHASE_W,
   parameter int DIV_W = dds_slope_pkg::DIV_W
) (
   input wire logic clock,
   input wire logic nrst,
   input wire dds_slope_pkg::core_setting_type [CORES-1:0] shadowSetting,
   input wire dds_slope_pkg::phase_policy_type phase_update_policy,
   input wire logic [DIV_W-1:0] freq_ramp_cycle_divider,
   input wire logic [DIV_W-1:0] level_ramp_cycle_divider,
   input wire dds_slope_pkg::command_type synth_command_port,
   input wire logic triggerEvent,
   output dds_slope_pkg::core_setting_type [CORES-1:0] activeSetting,
   output logic [CORES-1:0][FREQ_W-1:0] freqPhaseStep,
   output logic [CORES-1:0][LEVEL_W-1:0] core_output_level,
   output logic [CORES-1:0][PHASE_W-1:0] phaseCounter,
   output logic [CORES-1:0] phaseCounterCleared,
   output logic [FREQ_W-1:0] freq_ramp_rate_floor,
   output logic [FREQ_W-1:0] freq_ramp_rate_ceiling,
   output logic [FREQ_W-1:0] freq_ramp_rate_granule,
   output logic [LEVEL_W-1:0] level_ramp_rate_floor,
   output logic [LEVEL_W-1:0] level_ramp_rate_ceiling,
   output logic [LEVEL_W-1:0] level_ramp_rate_granule,
   output logic [DIV_W-1:0] freqDividerUsed,
   output logic [DIV_W-1:0] levelDividerUsed,
   output logic applyPulse
);
   logic applyNow;
   logic freqTick;
   logic levelTick;
   logic [DIV_W-1:0] next_freqDivider;
   logic [DIV_W-1:0] next_levelDivider;

   // Event-armed command waits for the trigger; immediate applies now
   logic armed;
   assign applyNow = (synth_command_port ==
                      dds_slope_pkg::apply_immediately_cmd)
                     || (armed && triggerEvent);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         armed <= 1'b0;
      end else if (synth_command_port ==
                   dds_slope_pkg::apply_on_event_cmd) begin
         armed <= 1'b1;
      end else if (applyNow) begin
         armed <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         applyPulse <= 1'b0;
      end else begin
         applyPulse <= applyNow;
      end
   end

   // Out-of-range dividers are clamped so readback shows the value used
   always_comb begin
      next_freqDivider = freq_ramp_cycle_divider;
      if (freq_ramp_cycle_divider < DIV_W'(dds_slope_pkg::DIV_MIN)) begin
         next_freqDivider = DIV_W'(dds_slope_pkg::DIV_MIN);
      end else if (freq_ramp_cycle_divider >
                   DIV_W'(dds_slope_pkg::DIV_MAX)) begin
         next_freqDivider = DIV_W'(dds_slope_pkg::DIV_MAX);
      end
      next_levelDivider = level_ramp_cycle_divider;
      if (level_ramp_cycle_divider < DIV_W'(dds_slope_pkg::DIV_MIN)) begin
         next_levelDivider = DIV_W'(dds_slope_pkg::DIV_MIN);
      end else if (level_ramp_cycle_divider >
                   DIV_W'(dds_slope_pkg::DIV_MAX)) begin
         next_levelDivider = DIV_W'(dds_slope_pkg::DIV_MAX);
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         freqDividerUsed <= dds_slope_pkg::DIV_RESET;
         levelDividerUsed <= dds_slope_pkg::DIV_RESET;
      end else begin
         freqDividerUsed <= next_freqDivider;
         levelDividerUsed <= next_levelDivider;
      end
   end

   ramp_pacer #(.DIV_W(DIV_W)) freqPacer (
      .clock(clock),
      .nrst(nrst),
      .divider(freqDividerUsed),
      .tick(freqTick)
   );

   ramp_pacer #(.DIV_W(DIV_W)) levelPacer (
      .clock(clock),
      .nrst(nrst),
      .divider(levelDividerUsed),
      .tick(levelTick)
   );

   // Fixed limits; rates are integer codes so any code from floor to ceiling is usable
   assign freq_ramp_rate_floor = dds_slope_pkg::FREQ_RATE_MIN;
   assign freq_ramp_rate_ceiling = dds_slope_pkg::FREQ_RATE_MAX;
   assign freq_ramp_rate_granule = dds_slope_pkg::FREQ_RATE_STEP;
   assign level_ramp_rate_floor = dds_slope_pkg::LEVEL_RATE_MIN;
   assign level_ramp_rate_ceiling = dds_slope_pkg::LEVEL_RATE_MAX;
   assign level_ramp_rate_granule = dds_slope_pkg::LEVEL_RATE_STEP;

   genvar c;
   generate
      for (c = 0; c < CORES; c++) begin : core
         logic signed [FREQ_W-1:0] freqValue;
         logic signed [LEVEL_W-1:0] levelValue;
         logic signed [LEVEL_W-1:0] levelRate;
         logic signed [FREQ_W-1:0] freqRate;
         logic [PHASE_W-1:0] phaseNext;
         dds_slope_pkg::core_setting_type used;

         // Rate rounding: level rate forced to zero on cores without ramp
         always_comb begin
            used = shadowSetting[c];
            freqRate = shadowSetting[c].freqRampRate;
            levelRate = LEVEL_RAMP_CORES[c] ?
                        shadowSetting[c].levelRampRate : '0;
            if (levelRate < dds_slope_pkg::LEVEL_RATE_MIN) begin
               levelRate = dds_slope_pkg::LEVEL_RATE_MIN;
            end
            if (freqRate < dds_slope_pkg::FREQ_RATE_MIN) begin
               freqRate = dds_slope_pkg::FREQ_RATE_MIN;
            end
            used.freqRampRate = freqRate;
            used.levelRampRate = levelRate;
            if (shadowSetting[c].outputLevel <
                dds_slope_pkg::LEVEL_MIN_CODE) begin
               used.outputLevel = dds_slope_pkg::LEVEL_MIN_CODE;
            end
         end

         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               activeSetting[c] <= '0;
            end else if (applyNow) begin
               activeSetting[c] <= used;
            end
         end

         ramp_accumulator #(
            .W(FREQ_W),
            .LOW(dds_slope_pkg::FREQ_MIN_CODE),
            .HIGH(dds_slope_pkg::FREQ_MAX_CODE)
         ) freqRamp (
            .clock(clock),
            .nrst(nrst),
            .load(applyNow),
            .loadValue(used.toneFrequency),
            .step(freqTick),
            .rate(activeSetting[c].freqRampRate),
            .value(freqValue)
         );

         ramp_accumulator #(
            .W(LEVEL_W),
            .LOW(dds_slope_pkg::LEVEL_MIN_CODE),
            .HIGH(dds_slope_pkg::LEVEL_MAX_CODE)
         ) levelRamp (
            .clock(clock),
            .nrst(nrst),
            .load(applyNow),
            .loadValue(used.outputLevel),
            .step(levelTick),
            .rate(activeSetting[c].levelRampRate),
            .value(levelValue)
         );

         assign freqPhaseStep[c] = freqValue;
         assign core_output_level[c] = levelValue;

         // Phase counter wraps over 4096 steps per turn
         // One policy input, sampled at the apply edge, serves every core
         always_comb begin
            phaseNext = phaseCounter[c] + freqValue[FREQ_W-1 -: PHASE_W];
            if (applyNow) begin
               if (phase_update_policy ==
                   dds_slope_pkg::phase_reload_policy) begin
                  phaseNext = shadowSetting[c].phaseOffset;
               end else begin
                  phaseNext = phaseNext +
                              shadowSetting[c].phaseOffset;
               end
            end
         end

         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               phaseCounter[c] <= '0;
               phaseCounterCleared[c] <= 1'b0;
            end else begin
               phaseCounter[c] <= phaseNext;
               phaseCounterCleared[c] <= applyNow &&
                  phase_update_policy ==
                  dds_slope_pkg::phase_reload_policy;
            end
         end
      end
   endgenerate
endmodule : dds_slope_and_phase_control
`default_nettype wire

// ===== dv/dds_slope_and_phase_control_assertions.sv
// Concurrent checks on the slope and phase-update block's ports.
// Assumes core 0 may ramp its level and core 1 may not.
`default_nettype none
module dds_slope_and_phase_control_assertions #(
   parameter int CORES = 4,
   parameter logic [CORES-1:0] LEVEL_RAMP_CORES = 4'h1
) (
   input wire logic clock,
   input wire logic nrst,
   input wire dds_slope_pkg::core_setting_type [CORES-1:0] shadowSetting,
   input wire dds_slope_pkg::phase_policy_type phase_update_policy,
   input wire dds_slope_pkg::command_type synth_command_port,
   input wire logic triggerEvent,
   input wire dds_slope_pkg::core_setting_type [CORES-1:0] activeSetting,
   input wire logic [CORES-1:0][31:0] freqPhaseStep,
   input wire logic [CORES-1:0] phaseCounterCleared,
   input wire logic [31:0] freq_ramp_rate_floor,
   input wire logic [15:0] level_ramp_rate_floor,
   input wire logic [12:0] freqDividerUsed,
   input wire logic [12:0] levelDividerUsed,
   input wire logic applyPulse
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   // An armed trigger may also apply, so only quiet cycles are idle
   wire logic idle = synth_command_port == dds_slope_pkg::cmd_idle
      && !triggerEvent;
   wire logic now = synth_command_port == dds_slope_pkg::apply_immediately_cmd;
   wire logic [31:0] f0 = freqPhaseStep[0];
   wire logic [31:0] rate0 = activeSetting[0].freqRampRate;
   wire logic add = phase_update_policy == dds_slope_pkg::phase_additive_policy;

   a_apply_now_pulse: assert property (
      now |=> applyPulse) else $error("no pulse after apply command");
   a_apply_freq_load: assert property (
      now && !shadowSetting[0].toneFrequency[31] |=>
      f0 == $past(shadowSetting[0].toneFrequency))
      else $error("frequency not loaded on apply");
   a_ramp_step_size: assert property (
      idle |=> f0 == $past(f0) || f0 == $past(f0) + $past(rate0)
      || f0 == 32'h7FFFFFFF || f0 == 32'h0)
      else $error("frequency moved by other than its rate");
   a_zero_rate_hold: assert property (
      idle && rate0 == 32'h0 |=> $stable(f0))
      else $error("frequency moved with zero rate");
   a_level_core_gate: assert property (
      LEVEL_RAMP_CORES[1] || activeSetting[1].levelRampRate == 16'h0)
      else $error("level rate on core without level ramp");
   a_freq_div_range: assert property (
      freqDividerUsed >= 13'h1 && freqDividerUsed <= 13'h1000)
      else $error("frequency divider out of range");
   a_level_div_range: assert property (
      levelDividerUsed >= 13'h1 && levelDividerUsed <= 13'h1000)
      else $error("level divider out of range");
   a_rate_floor_const: assert property (
      freq_ramp_rate_floor == dds_slope_pkg::FREQ_RATE_MIN
      && level_ramp_rate_floor == dds_slope_pkg::LEVEL_RATE_MIN)
      else $error("rate floor constant wrong");
   a_freq_rate_round: assert property (
      rate0 != 32'h80000000) else $error("unrounded frequency rate");
   a_reload_clears: assert property (
      now && !add |=> phaseCounterCleared[0])
      else $error("reload apply did not clear phase");
   a_additive_keeps: assert property (
      now && add |=> !phaseCounterCleared[0])
      else $error("additive apply cleared phase");
   cover property (now && add);
   cover property (triggerEvent ##1 applyPulse);
   cover property (f0 == 32'h7FFFFFFF);
endmodule : dds_slope_and_phase_control_assertions
`default_nettype wire

// ===== dv/host_setting_model.sv
// Host side: holds the pending per-core settings that software writes.
// Assumes one write per request, applied at the next clock edge.
`default_nettype none
module host_setting_model (
   input wire logic clock,
   input wire logic nrst,
   input wire logic wrEnable,
   input wire logic [1:0] wrCore,
   input wire dds_slope_pkg::core_setting_type wrValue,
   output dds_slope_pkg::core_setting_type [3:0] shadowSetting
);
   // Signed rates, levels and phase codes pass as written
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         shadowSetting <= '0;
      end else if (wrEnable) begin
         shadowSetting[wrCore] <= wrValue;
      end
   end
endmodule : host_setting_model
`default_nettype wire

// ===== dv/dds_slope_and_phase_control_tb.sv
// Self-checking bench for the slope and phase-update block.
// Assumes four cores, level ramps on core 0 only.
`default_nettype none
module dds_slope_and_phase_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 0;
   logic nrst = 0;
   logic wrEnable = 0;
   logic [1:0] wrCore = 2'h0;
   dds_slope_pkg::core_setting_type wrValue = '0;
   dds_slope_pkg::core_setting_type [3:0] shadow, active;
   dds_slope_pkg::phase_policy_type policy = dds_slope_pkg::phase_reload_policy;
   dds_slope_pkg::command_type cmd = dds_slope_pkg::cmd_idle;
   logic [12:0] freqDiv = 13'h1, levelDiv = 13'h1, fUsed, lUsed;
   logic trig = 0, applied;
   logic [3:0][31:0] freq;
   logic [3:0][15:0] level;
   logic [3:0][11:0] phase;
   logic [3:0] cleared;
   logic [31:0] fFloor, fCeil, fGran;
   logic [15:0] lFloor, lCeil, lGran;
   int failures = 0, cmpCount = 0;

   initial forever #4 clock = ~clock;

   host_setting_model host_setting_model_inst (.clock(clock), .nrst(nrst),
      .wrEnable(wrEnable), .wrCore(wrCore), .wrValue(wrValue),
      .shadowSetting(shadow));
   dds_slope_and_phase_control dds_slope_and_phase_control_inst (
      .clock(clock), .nrst(nrst), .shadowSetting(shadow),
      .phase_update_policy(policy), .freq_ramp_cycle_divider(freqDiv),
      .level_ramp_cycle_divider(levelDiv), .synth_command_port(cmd),
      .triggerEvent(trig), .activeSetting(active), .freqPhaseStep(freq),
      .core_output_level(level), .phaseCounter(phase),
      .phaseCounterCleared(cleared), .freq_ramp_rate_floor(fFloor),
      .freq_ramp_rate_ceiling(fCeil), .freq_ramp_rate_granule(fGran),
      .level_ramp_rate_floor(lFloor), .level_ramp_rate_ceiling(lCeil),
      .level_ramp_rate_granule(lGran), .freqDividerUsed(fUsed),
      .levelDividerUsed(lUsed), .applyPulse(applied));

   task automatic step(int n = 1);
      repeat (n) @(posedge clock);
      #1;
   endtask : step

   task automatic chk(logic [31:0] got, logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", cmpCount, failures);
      if (failures == 0 && cmpCount > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   task automatic put(logic [1:0] c, logic [31:0] f, logic [31:0] fr,
      logic [15:0] l, logic [15:0] lr, logic [11:0] p);
      wrCore = c;
      wrValue = '{f, l, p, fr, lr};
      wrEnable = 1;
      step;
      wrEnable = 0;
   endtask : put

   task automatic issue(dds_slope_pkg::command_type c);
      cmd = c;
      step;
      cmd = dds_slope_pkg::cmd_idle;
   endtask : issue

   function automatic logic [31:0] pick(bit lvl);
      return lvl ? {16'h0, level[0]} : freq[0];
   endfunction : pick

   // Counts cycles to the next change; a stuck ramp ends the run
   task automatic waitMove(bit lvl, output int n);
      logic [31:0] v;
      v = pick(lvl);
      n = 0;
      while (pick(lvl) === v) begin
         n++;
         step;
         if (n > 60) begin
            failures++;
            summarize;
         end
      end
   endtask : waitMove

   initial begin
      int n;
      step(2);
      nrst = 1;
      chk(fUsed, 32'h1);
      chk(fFloor, dds_slope_pkg::FREQ_RATE_MIN);
      chk(fCeil, dds_slope_pkg::FREQ_RATE_MAX);
      chk(fGran, dds_slope_pkg::FREQ_RATE_STEP);
      chk(lFloor, {16'h0, dds_slope_pkg::LEVEL_RATE_MIN});
      chk(lCeil, dds_slope_pkg::LEVEL_RATE_MAX);
      chk(lGran, dds_slope_pkg::LEVEL_RATE_STEP);
      freqDiv = 13'h0;
      levelDiv = 13'h1388;
      step(2);
      chk(fUsed, 32'h1);
      chk(lUsed, 32'h1000);
      freqDiv = 13'h3;
      levelDiv = 13'h2;
      put(0, 32'h100, 32'h5, 16'h10, 16'h0, 12'h0);
      issue(dds_slope_pkg::apply_immediately_cmd);
      chk(freq[0], 32'h100);
      chk(applied, 32'h1);
      waitMove(0, n);
      chk(freq[0], 32'h105);
      waitMove(0, n);
      chk(freq[0], 32'h10A);
      chk(n, 32'h3);
      put(0, 32'h200, 32'h0, 16'h10, 16'hFFFD, 12'h0);
      issue(dds_slope_pkg::apply_immediately_cmd);
      waitMove(1, n);
      chk(level[0], 32'hD);
      waitMove(1, n);
      chk(level[0], 32'hA);
      chk(n, 32'h2);
      chk(freq[0], 32'h200);
      freqDiv = 13'h1;
      levelDiv = 13'h1;
      put(0, 32'h9, 32'hFFFFFFFC, 16'h8003, 16'hFFFF, 12'h0);
      issue(dds_slope_pkg::apply_immediately_cmd);
      step(10);
      chk(freq[0], 32'h0);
      chk(level[0], 32'h8001);
      put(0, 32'h7FFFFFFD, 32'h2, 16'h7FFD, 16'h1, 12'h0);
      issue(dds_slope_pkg::apply_immediately_cmd);
      step(10);
      chk(freq[0], 32'h7FFFFFFF);
      chk(level[0], 32'h7FFF);
      put(0, 32'h0, 32'h80000000, 16'h0, 16'h8000, 12'h0);
      issue(dds_slope_pkg::apply_immediately_cmd);
      chk(active[0].freqRampRate, 32'h80000001);
      chk({16'h0, active[0].levelRampRate}, 32'h8001);
      put(1, 32'h0, 32'h0, 16'h20, 16'h1, 12'h0);
      issue(dds_slope_pkg::apply_immediately_cmd);
      step(5);
      chk(active[1].levelRampRate, 32'h0);
      chk(level[1], 32'h20);
      put(0, 32'h40, 32'h0, 16'h0, 16'h0, 12'h0);
      trig = 1;
      step;
      trig = 0;
      chk(applied, 32'h0);
      issue(dds_slope_pkg::apply_on_event_cmd);
      chk(freq[0], 32'h0);
      step(3);
      trig = 1;
      step;
      trig = 0;
      chk(freq[0], 32'h40);
      put(0, 32'h0, 32'h0, 16'h0, 16'h0, 12'h800);
      issue(dds_slope_pkg::apply_immediately_cmd);
      chk(cleared[0], 32'h1);
      chk(phase[0], 32'h800);
      policy = dds_slope_pkg::phase_additive_policy;
      put(0, 32'h0, 32'h0, 16'h0, 16'h0, 12'hC00);
      issue(dds_slope_pkg::apply_immediately_cmd);
      chk(phase[0], 32'h400);
      chk(cleared[0], 32'h0);
      policy = dds_slope_pkg::phase_reload_policy;
      put(0, 32'h0, 32'h0, 16'h0, 16'h0, 12'h800);
      issue(dds_slope_pkg::apply_immediately_cmd);
      chk(phase[0], 32'h800);
      // Top twelve frequency bits give one phase step per cycle
      put(0, 32'h00100000, 32'h0, 16'h0, 16'h0, 12'h0);
      issue(dds_slope_pkg::apply_immediately_cmd);
      chk(phase[0], 32'h0);
      step(4);
      chk(phase[0], 32'h4);
      summarize;
   end
endmodule : dds_slope_and_phase_control_tb

bind dds_slope_and_phase_control dds_slope_and_phase_control_assertions #(
   .CORES(CORES), .LEVEL_RAMP_CORES(LEVEL_RAMP_CORES)) checkerInst (
   .clock(clock), .nrst(nrst), .shadowSetting(shadowSetting),
   .phase_update_policy(phase_update_policy),
   .synth_command_port(synth_command_port), .triggerEvent(triggerEvent),
   .activeSetting(activeSetting), .freqPhaseStep(freqPhaseStep),
   .phaseCounterCleared(phaseCounterCleared),
   .freq_ramp_rate_floor(freq_ramp_rate_floor),
   .level_ramp_rate_floor(level_ramp_rate_floor),
   .freqDividerUsed(freqDividerUsed), .levelDividerUsed(levelDividerUsed),
   .applyPulse(applyPulse));
`default_nettype wire
